//--- hw/retimer_misc_output_control_regs.sv
// Link and output-swing control registers of the retimer, with clock-ratio snooping
`include "retimer_ctl_defs.svh"

// Contract
// RL1 - Termination field: 00 none, 01 150-300 ohm, 11 75-150 ohm, 10 reserved.
// RL2 - Strap mode mirrors termination strap; host writes to the field are dropped.
// RL3 - Bridge rate bit selects 100 kbps when clear, 400 kbps when set.
// RL4 - Software sets the power-down inhibit before choosing 400 kbps.
// RL5 - Snooped write to 0xA8 offset 0x20 copies bit 1 into the ratio flag.
// RL6 - Ratio flag clears after hot-plug stays low beyond 2 ms.
// RL7 - Ratio flag 0 means clock at one tenth, 1 at one fortieth.
// RL8 - Training disable clear enables training; set keeps legacy low-rate modes only.
// RL9 - Setting training disable forces the ratio flag to one.
// RL10 - Data swing: 000 resistor level, 001-011 raise, 100-111 lower.
// RL11 - Clock swing uses same coding; default follows resistor and half-swing disable.
// RL12 - Retimer mode only: de-emphasis 00 none, 01 2 dB, others reserved.
// RL13 - De-emphasis follows its strap; host writes ignored in strap mode.
// RL14 - Termination, de-emphasis and swing reach lanes only on the apply bit.
// RL15 - Hot-plug low time counted on core clock; restarts on reassertion.
module retimer_misc_output_control_regs
    import retimer_ctl_pkg::*;
#(
    parameter int HPD_LOSS_CYCLES =
        (`RC_HPD_LOSS_NS + `RC_CLK_PERIOD_NS - 1) / `RC_CLK_PERIOD_NS
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr_en,
    input  wire logic [7:0] i_reg_wr_data,
    input  wire logic       i_reg_rd_en,
    output logic [7:0]      o_reg_rd_data,
    output logic            o_reg_rd_valid,
    input  wire logic       i_config_select,
    input  wire logic [1:0] i_termination_strap,
    input  wire logic [1:0] i_post_cursor_strap,
    input  wire logic       i_retimer_mode,
    input  wire logic       i_clock_half_swing_disable,
    input  wire logic       i_sink_hot_plug_in,
    input  wire logic       i_source_side_clock_line,
    input  wire logic       i_source_side_data_line,
    output logic [1:0]      o_out_termination_select,
    output logic [2:0]      o_data_swing_adjust,
    output logic [2:0]      o_clock_swing_adjust,
    output logic [1:0]      o_post_cursor_weight,
    output logic            o_clock_half_swing,
    output logic            o_bridge_rate_select,
    output logic            o_training_disable,
    output logic            o_clock_ratio_flag
);

    localparam int PINS = 5;

    function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
        hits = (addr == target);
    endfunction : hits

    logic [PINS-1:0] pin_raw;
    logic [PINS-1:0] pin_s1_reg;
    logic [PINS-1:0] pin_s2_reg;
    logic [PINS-1:0] pin_s3_reg;
    logic [PINS-1:0] pin_reg;
    logic            strap_mode;
    logic [1:0]      term_strap;
    logic [1:0]      post_strap;

    logic [1:0]      term_reg;
    logic            rate_reg;
    logic            train_reg;
    logic            ratio_reg;
    logic [2:0]      dswing_reg;
    logic [2:0]      cswing_reg;
    logic [1:0]      post_reg;
    logic [1:0]      post_applied_reg;

    logic            wr_misc;
    logic            wr_swing;
    logic            apply_pulse;
    logic            snoop_write;
    logic            snoop_value;
    logic            hot_plug_lost;
    reg_byte_t       rd_next;

    assign pin_raw = {i_config_select, i_termination_strap, i_post_cursor_strap};

    // Each strap pin gets its own three-stage filter
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin_sync
            always_ff @(posedge i_core_clk) begin
                if (i_sys_rst) begin
                    pin_s1_reg[g] <= 1'b0;
                    pin_s2_reg[g] <= 1'b0;
                    pin_s3_reg[g] <= 1'b0;
                    pin_reg[g]    <= 1'b0;
                end else begin
                    pin_s1_reg[g] <= pin_raw[g];
                    pin_s2_reg[g] <= pin_s1_reg[g];
                    pin_s3_reg[g] <= pin_s2_reg[g];
                    if (pin_s2_reg[g] == pin_s3_reg[g]) begin
                        pin_reg[g] <= pin_s3_reg[g];
                    end
                end
            end
        end
    endgenerate

    // Reset reads as strap mode until the select pin settles high
    assign strap_mode = !pin_reg[4];
    assign term_strap = pin_reg[3:2];
    assign post_strap = pin_reg[1:0];

    assign wr_misc     = i_reg_wr_en && hits(i_reg_addr, `RC_ADDR_MISC);
    assign wr_swing    = i_reg_wr_en && hits(i_reg_addr, `RC_ADDR_SWING);
    assign apply_pulse = i_reg_wr_en && hits(i_reg_addr, `RC_ADDR_APPLY)
                         && i_reg_wr_data[`RC_APPLY_BIT];

    source_channel_snoop u_snoop (
        .i_core_clk               (i_core_clk),
        .i_sys_rst                (i_sys_rst),
        .i_source_side_clock_line (i_source_side_clock_line),
        .i_source_side_data_line  (i_source_side_data_line),
        .o_ratio_write            (snoop_write),
        .o_ratio_value            (snoop_value)
    );

    hot_plug_timer #(
        .LOSS_CYCLES (HPD_LOSS_CYCLES)
    ) u_hpd_timer (
        .i_core_clk         (i_core_clk),
        .i_sys_rst          (i_sys_rst),
        .i_sink_hot_plug_in (i_sink_hot_plug_in),
        .o_hot_plug_lost    (hot_plug_lost)
    );

    // Termination field: strap wins over the host in strap mode
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            term_reg <= `RC_TERM_RESET; // RL1
        end else if (strap_mode) begin
            term_reg <= term_strap; // RL2
        end else if (wr_misc) begin
            term_reg <= i_reg_wr_data[`RC_TERM_MSB:`RC_TERM_LSB]; // RL1
        end
    end

    // Rate takes effect at once; the inhibit ordering is left to software
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rate_reg  <= 1'b0;
            train_reg <= 1'b0;
        end else if (wr_misc) begin
            rate_reg  <= i_reg_wr_data[`RC_RATE_BIT]; // RL3
            train_reg <= i_reg_wr_data[`RC_TRAIN_BIT]; // RL8
        end
    end

    // Ratio flag: force beats snoop, snoop beats the hot-plug clear
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ratio_reg <= 1'b0;
        end else if (train_reg) begin
            ratio_reg <= 1'b1; // RL9
        end else if (snoop_write) begin
            ratio_reg <= snoop_value; // RL5
        end else if (hot_plug_lost) begin
            ratio_reg <= 1'b0; // RL6
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            dswing_reg <= `RC_SWING_RESET; // RL10
            cswing_reg <= `RC_SWING_RESET; // RL11
        end else if (wr_swing) begin
            dswing_reg <= i_reg_wr_data[`RC_DSWING_MSB:`RC_DSWING_LSB]; // RL10
            cswing_reg <= i_reg_wr_data[`RC_CSWING_MSB:`RC_CSWING_LSB]; // RL11
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            post_reg <= `RC_POST_RESET; // RL12
        end else if (strap_mode) begin
            post_reg <= post_strap; // RL13
        end else if (wr_swing) begin
            post_reg <= i_reg_wr_data[`RC_POST_MSB:`RC_POST_LSB]; // RL13
        end
    end

    // Lane copies move only on apply, so a half-written set never glitches the lanes
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_out_termination_select <= `RC_TERM_RESET;
            o_data_swing_adjust      <= `RC_SWING_RESET;
            o_clock_swing_adjust     <= `RC_SWING_RESET;
            post_applied_reg         <= `RC_POST_RESET;
        end else if (apply_pulse) begin
            o_out_termination_select <= term_reg; // RL14
            o_data_swing_adjust      <= dswing_reg; // RL14
            o_clock_swing_adjust     <= cswing_reg; // RL14
            post_applied_reg         <= post_reg; // RL14
        end
    end

    // De-emphasis is meaningless in redriver mode, so it is withheld there
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_post_cursor_weight <= `RC_POST_NONE;
        end else begin
            o_post_cursor_weight <= i_retimer_mode ? post_applied_reg : `RC_POST_NONE; // RL12
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_clock_half_swing <= 1'b0;
        end else begin
            o_clock_half_swing <= ratio_reg && !i_clock_half_swing_disable; // RL11
        end
    end

    assign o_bridge_rate_select = rate_reg; // RL3
    assign o_training_disable   = train_reg; // RL8
    assign o_clock_ratio_flag   = ratio_reg; // RL7

    always_comb begin
        rd_next = `RC_BYTE_ZERO;
        if (hits(i_reg_addr, `RC_ADDR_MISC)) begin
            rd_next[`RC_TERM_MSB:`RC_TERM_LSB] = term_reg;
            rd_next[`RC_RATE_BIT]              = rate_reg;
            rd_next[`RC_RATIO_BIT]             = ratio_reg;
            rd_next[`RC_TRAIN_BIT]             = train_reg;
        end else if (hits(i_reg_addr, `RC_ADDR_SWING)) begin
            rd_next[`RC_DSWING_MSB:`RC_DSWING_LSB] = dswing_reg;
            rd_next[`RC_CSWING_MSB:`RC_CSWING_LSB] = cswing_reg;
            rd_next[`RC_POST_MSB:`RC_POST_LSB]     = post_reg;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_reg_rd_data  <= `RC_BYTE_ZERO;
            o_reg_rd_valid <= 1'b0;
        end else begin
            o_reg_rd_valid <= i_reg_rd_en;
            if (i_reg_rd_en) begin
                o_reg_rd_data <= rd_next;
            end
        end
    end

    AST_TERM_STRAP: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL2
        strap_mode |=> term_reg == $past(term_strap))
        else $error("Termination did not mirror its strap");

    AST_TERM_WRITE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL1
        (!strap_mode && wr_misc) |=> term_reg == $past(i_reg_wr_data[`RC_TERM_MSB:`RC_TERM_LSB]))
        else $error("Termination write lost");

    AST_RATE_WRITE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL3
        wr_misc |=> o_bridge_rate_select == $past(i_reg_wr_data[`RC_RATE_BIT]))
        else $error("Bridge rate write lost");

    AST_RATIO_SNOOP: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL5
        (snoop_write && !train_reg) |=> o_clock_ratio_flag == $past(snoop_value))
        else $error("Snooped ratio write not taken");

    AST_RATIO_LOSS: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL6
        (hot_plug_lost && !snoop_write && !train_reg) |=> !o_clock_ratio_flag)
        else $error("Ratio flag survived hot-plug loss");

    AST_TRAIN_FORCE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL9
        (wr_misc && i_reg_wr_data[`RC_TRAIN_BIT]) |=> ##1 o_clock_ratio_flag)
        else $error("Training disable did not force ratio");

    AST_APPLY_LOAD: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL14
        apply_pulse |=> (o_out_termination_select == $past(term_reg))
                        && (o_data_swing_adjust == $past(dswing_reg)))
        else $error("Apply did not load lane settings");

    AST_APPLY_HOLD: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL14
        !apply_pulse |=> $stable(o_out_termination_select) && $stable(o_clock_swing_adjust))
        else $error("Lane settings moved without apply");

    AST_POST_MODE: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL12
        !i_retimer_mode |=> o_post_cursor_weight == `RC_POST_NONE)
        else $error("De-emphasis outside retimer mode");

    AST_POST_STRAP: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL13
        (strap_mode && wr_swing) |=> post_reg == $past(post_strap))
        else $error("De-emphasis write taken in strap mode");

    AST_READ_MISC: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL7
        (i_reg_rd_en && hits(i_reg_addr, `RC_ADDR_MISC)) |=> o_reg_rd_valid
            && o_reg_rd_data[`RC_RATIO_BIT] == $past(ratio_reg))
        else $error("Ratio flag readback wrong");

endmodule : retimer_misc_output_control_regs

//--- pkg/retimer_ctl_defs.svh
// Offsets, field positions, reset values and timing figures of the retimer control bank
`ifndef RETIMER_CTL_DEFS_SVH
`define RETIMER_CTL_DEFS_SVH

`define RC_ADDR_APPLY        8'h0A
`define RC_ADDR_MISC         8'h0B
`define RC_ADDR_SWING        8'h0C

`define RC_APPLY_BIT         2
`define RC_TERM_MSB          4
`define RC_TERM_LSB          3
`define RC_RATE_BIT          2
`define RC_RATIO_BIT         1
`define RC_TRAIN_BIT         0
`define RC_DSWING_MSB        7
`define RC_DSWING_LSB        5
`define RC_CSWING_MSB        4
`define RC_CSWING_LSB        2
`define RC_POST_MSB          1
`define RC_POST_LSB          0

`define RC_TERM_RESET        2'h0
`define RC_SWING_RESET       3'h0
`define RC_POST_RESET        2'h0
`define RC_POST_NONE         2'h0
`define RC_BYTE_ZERO         8'h00

`define RC_SNOOP_SLAVE       8'hA8
`define RC_SNOOP_OFFSET      8'h20
`define RC_SNOOP_BIT         1
`define RC_BITS_PER_BYTE     4'h8

`define RC_CLK_PERIOD_NS     4
`define RC_HPD_LOSS_NS       2000000

`endif

//--- pkg/retimer_ctl_pkg.sv
// Types shared by the retimer control bank
package retimer_ctl_pkg;

    typedef enum logic [2:0] {
        SNOOP_IDLE,
        SNOOP_ADDR,
        SNOOP_OFFSET,
        SNOOP_DATA,
        SNOOP_SKIP
    } snoop_state_t;

    typedef logic [7:0] reg_byte_t;

endpackage : retimer_ctl_pkg

//--- hw/source_channel_snoop.sv
// Passive watcher of source-side two-wire writes to the clock-ratio location
`include "retimer_ctl_defs.svh"

module source_channel_snoop
    import retimer_ctl_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_source_side_clock_line,
    input  wire logic i_source_side_data_line,
    output logic      o_ratio_write,
    output logic      o_ratio_value
);

    logic [2:0]   scl_sync_reg;
    logic [2:0]   sda_sync_reg;
    logic         scl_reg;
    logic         sda_reg;
    logic         scl_prev_reg;
    logic         sda_prev_reg;
    snoop_state_t state_reg;
    logic [3:0]   bit_cnt_reg;
    reg_byte_t    shift_reg;
    reg_byte_t    offset_reg;
    logic         scl_rise;
    logic         start_seen;
    logic         stop_seen;

    // Pins are asynchronous; a level counts once stages two and three agree
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], i_source_side_clock_line};
            sda_sync_reg <= {sda_sync_reg[1:0], i_source_side_data_line};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            scl_reg      <= 1'b1;
            sda_reg      <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_reg <= sda_sync_reg[2];
            end
            scl_prev_reg <= scl_reg;
            sda_prev_reg <= sda_reg;
        end
    end

    assign scl_rise   = scl_reg && !scl_prev_reg;
    assign start_seen = scl_reg && scl_prev_reg && sda_prev_reg && !sda_reg;
    assign stop_seen  = scl_reg && scl_prev_reg && !sda_prev_reg && sda_reg;

    // Byte framing; the ninth clock is the acknowledge slot, where a byte is judged
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_reg     <= SNOOP_IDLE;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= `RC_BYTE_ZERO;
            offset_reg    <= `RC_BYTE_ZERO;
            o_ratio_write <= 1'b0;
            o_ratio_value <= 1'b0;
        end else begin
            o_ratio_write <= 1'b0;
            if (start_seen) begin
                state_reg   <= SNOOP_ADDR;
                bit_cnt_reg <= 4'h0;
            end else if (stop_seen) begin
                state_reg <= SNOOP_IDLE;
            end else if (scl_rise && state_reg != SNOOP_IDLE) begin
                if (bit_cnt_reg != `RC_BITS_PER_BYTE) begin
                    shift_reg   <= {shift_reg[6:0], sda_reg};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end else begin
                    bit_cnt_reg <= 4'h0;
                    unique case (state_reg)
                        SNOOP_IDLE: state_reg <= SNOOP_IDLE;
                        SNOOP_ADDR: begin
                            // Reads and other targets are ignored to the stop
                            state_reg <= (shift_reg == `RC_SNOOP_SLAVE) ? SNOOP_OFFSET
                                                                        : SNOOP_SKIP;
                        end
                        SNOOP_OFFSET: begin
                            offset_reg <= shift_reg;
                            state_reg  <= SNOOP_DATA;
                        end
                        SNOOP_DATA: begin
                            if (offset_reg == `RC_SNOOP_OFFSET) begin // RL5
                                o_ratio_write <= 1'b1;
                                o_ratio_value <= shift_reg[`RC_SNOOP_BIT];
                            end
                            // Burst writes walk the offset like the sink does
                            offset_reg <= offset_reg + 8'h01;
                        end
                        SNOOP_SKIP: state_reg <= SNOOP_SKIP;
                    endcase
                end
            end
        end
    end

endmodule : source_channel_snoop

//--- hw/hot_plug_timer.sv
// Times how long the sink hot-plug input has stayed low
`include "retimer_ctl_defs.svh"

module hot_plug_timer #(
    parameter int LOSS_CYCLES = 500000
) (
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_sink_hot_plug_in,
    output logic      o_hot_plug_lost
);

    localparam int CW = $clog2(LOSS_CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(LOSS_CYCLES);

    logic [2:0]    hp_sync_reg;
    logic          hp_reg;
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            hp_sync_reg <= 3'h0;
            hp_reg      <= 1'b0;
        end else begin
            hp_sync_reg <= {hp_sync_reg[1:0], i_sink_hot_plug_in};
            if (hp_sync_reg[1] == hp_sync_reg[2]) begin
                hp_reg <= hp_sync_reg[2];
            end
        end
    end

    // Saturates so a long unplug keeps the loss level up
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cnt_reg <= '0;
        end else if (hp_reg) begin
            cnt_reg <= '0; // RL15
        end else if (cnt_reg != LIMIT) begin
            cnt_reg <= cnt_reg + CW'(1); // RL15
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_hot_plug_lost <= 1'b0;
        end else begin
            o_hot_plug_lost <= !hp_reg && (cnt_reg == LIMIT); // RL6
        end
    end

    AST_HPD_RESTART: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RL15
        hp_reg |=> (cnt_reg == '0) ##1 !o_hot_plug_lost)
        else $error("Hot-plug counter did not restart");

endmodule : hot_plug_timer

//--- tb/source_side_model.sv
// Source-side two-wire master driving the snooped channel
module source_side_model (
    output logic o_clock_line,
    output logic o_data_line
);
    timeunit 1ns;
    timeprecision 100ps;
    // Lines idle high between frames, as the pull-ups leave them
    initial begin
        o_clock_line = 1'b1;
        o_data_line  = 1'b1;
    end
    // Data moves an eighth of a period after the clock falls, never on the edge
    task automatic put_bit(input logic b);
        #10 o_data_line = b;
        #30 o_clock_line = 1'b1;
        #40 o_clock_line = 1'b0;
    endtask : put_bit
    task automatic send(input logic [7:0] slave, input logic [7:0] offset,
                        input logic [7:0] data);
        logic [23:0] frame;
        frame = {slave, offset, data};
        o_data_line = 1'b0; // Start while clock high
        #40 o_clock_line = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            put_bit(frame[i]);
            if (i % 8 == 0) begin
                put_bit(1'b1); // Ack slot released to the pull-up
            end
        end
        #10 o_data_line = 1'b0;
        #30 o_clock_line = 1'b1;
        #40 o_data_line = 1'b1; // Stop
        #40;
    endtask : send
endmodule : source_side_model

//--- tb/retimer_misc_output_control_regs_bench.sv
// Self-checking bench of the retimer control bank
`include "retimer_ctl_defs.svh"
module retimer_misc_output_control_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LOSS = 20;
    int          bad_count = 0;
    int          checked   = 0;
    int          seed;
    logic        clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, cfg = 1'b0;
    logic        rtm = 1'b0, hsd = 1'b0, hpd = 1'b1, rvalid, rate, train, flag, half;
    logic        scl, sda;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, misc;
    logic [1:0]  tstrap = 2'h1, pstrap = 2'h1, term, post, pterm;
    logic [2:0]  dsw, csw, pdsw;
    logic [31:0] r;
    always #2 clk = ~clk;
    source_side_model src (.o_clock_line(scl), .o_data_line(sda));
    retimer_misc_output_control_regs #(.HPD_LOSS_CYCLES(LOSS)) dut (
        .i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr_en(wr_en),
        .i_reg_wr_data(wdata), .i_reg_rd_en(rd_en), .o_reg_rd_data(rdata),
        .o_reg_rd_valid(rvalid), .i_config_select(cfg), .i_termination_strap(tstrap),
        .i_post_cursor_strap(pstrap), .i_retimer_mode(rtm),
        .i_clock_half_swing_disable(hsd), .i_sink_hot_plug_in(hpd),
        .i_source_side_clock_line(scl), .i_source_side_data_line(sda),
        .o_out_termination_select(term), .o_data_swing_adjust(dsw),
        .o_clock_swing_adjust(csw), .o_post_cursor_weight(post), .o_clock_half_swing(half),
        .o_bridge_rate_select(rate), .o_training_disable(train), .o_clock_ratio_flag(flag));
    task automatic final_report;
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr  = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        chk({7'h00, rvalid}, 8'h01, "read valid");
        chk(rdata, exp, "read data");
    endtask : rd
    // Bounded wait; a flag that never arrives ends the run
    task automatic wait_flag(input logic v);
        int n;
        n = 0;
        while (flag !== v && n < LOSS + 80) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, flag}, {7'h00, v}, "ratio flag");
        if (n >= LOSS + 80) begin
            final_report();
        end
    endtask : wait_flag
    function automatic logic [7:0] misc_byte(input logic [1:0] t, input logic rt);
        return {3'h0, t, rt, 2'h0};
    endfunction : misc_byte
    initial begin
        seed = 32'h9641;
        settle(16);
        rst = 1'b0;
        settle(8);
        chk(term, 2'h0, "term reset");
        // Strap mode mirrors the de-emphasis strap, so its field reads 01
        rd(`RC_ADDR_SWING, 8'h01);
        rd(8'h55, `RC_BYTE_ZERO);
        rtm = 1'b1;
        wr(`RC_ADDR_MISC, 8'h18);
        wr(`RC_ADDR_SWING, 8'h02);
        rd(`RC_ADDR_MISC, 8'h08);
        rd(`RC_ADDR_SWING, 8'h01);
        chk(term, 2'h0, "term before apply");
        wr(`RC_ADDR_APPLY, 8'h04);
        settle(1);
        chk(term, 2'h1, "strap term");
        chk(post, 2'h1, "strap post");
        $display("test strap mode done");
        cfg = 1'b1;
        settle(8);
        pterm = 2'h1;
        pdsw  = 3'h0;
        for (int k = 0; k < 8; k++) begin
            r   = $random(seed);
            rtm = r[16];
            hsd = r[17];
            misc = misc_byte(k[1:0], r[2]);
            // Power-down inhibit lives outside this bank and is taken as set
            wr(`RC_ADDR_MISC, misc);
            wr(`RC_ADDR_SWING, r[15:8]);
            chk(term, pterm, "term held");
            chk(dsw, pdsw, "swing held");
            rd(`RC_ADDR_MISC, misc);
            chk(rate, r[2], "bridge rate");
            wr(`RC_ADDR_APPLY, 8'h04);
            settle(1);
            chk(term, k[1:0], "term");
            chk(dsw, r[15:13], "data swing");
            chk(csw, r[12:10], "clock swing");
            chk(post, rtm ? r[9:8] : 2'h0, "post cursor");
            pterm = k[1:0];
            pdsw  = r[15:13];
        end
        $display("test host fields done");
        for (int v = 0; v < 3; v++) begin
            src.send(`RC_SNOOP_SLAVE, `RC_SNOOP_OFFSET, {6'h00, v[0] == 1'b0, 1'b0});
            wait_flag(v[0] == 1'b0);
        end
        rd(`RC_ADDR_MISC, misc | 8'h02);
        chk(half, !hsd, "half swing");
        src.send(`RC_SNOOP_SLAVE, 8'h21, 8'h00);
        src.send(8'hA9, `RC_SNOOP_OFFSET, 8'h00);
        settle(20);
        chk(flag, 1'b1, "other targets");
        $display("test snoop done");
        for (int j = 0; j < 3; j++) begin
            hpd = 1'b0;
            settle(LOSS - 4);
            hpd = 1'b1;
            settle(6);
        end
        chk(flag, 1'b1, "short loss");
        hpd = 1'b0;
        wait_flag(1'b0);
        hpd = 1'b1;
        $display("test hot plug done");
        wr(`RC_ADDR_MISC, misc | 8'h01);
        wait_flag(1'b1);
        chk(train, 1'b1, "training disable");
        rst = 1'b1;
        settle(4);
        rst = 1'b0;
        settle(1);
        chk(flag, 1'b0, "flag after reset");
        chk(train, 1'b0, "train after reset");
        $display("test training and reset done");
        final_report();
    end
endmodule : retimer_misc_output_control_regs_bench
